// ==== src/scp_regs.vh ====
`ifndef SCP_REGS_VH
`define SCP_REGS_VH
// Command byte fields
`define SCP_CMD_RW_BIT     7
`define SCP_CMD_CLS_HI     4
`define SCP_CMD_CLS_LO     3
`define SCP_CMD_CNT_HI     2
`define SCP_CMD_CNT_LO     0
`define SCP_CMD_ADR_HI     6
`define SCP_CMD_ADR_LO     5
// Command classes on bits 4:3
`define SCP_CLS_CHAN       2'b10
`define SCP_CLS_COMMON     2'b11
// Identification byte, arbitrary value
`define SCP_ID_BYTE        8'h5a
// Storage geometry
`define SCP_CHAN_REGS      8
`define SCP_COMMON_REGS    8
`define SCP_COEF_WORDS     8
`define SCP_MEM_DEPTH      128
// Memory base addresses per class, then address constants; coefficient banks need four times eight words
`define SCP_BASE_CHAN      7'h00
`define SCP_BASE_COMMON    7'h20
`define SCP_BASE_COEF      7'h28
`define SCP_ADDR_ZERO      7'h00
`define SCP_ADDR_ONE       7'h01
// Reset value and last bit count of a byte
`define SCP_BYTE_ZERO      8'h00
`define SCP_BIT_CNT_LAST   3'h7
`endif

// ==== src/scp_sync.v ====
`timescale 1ns/1ps
// Two-stage synchroniser for one level from outside the clock domain
module scp_sync #(
  parameter [0:0] INIT = 1'b0
) (
  // Clock and reset
  input  wire clk,
  input  wire arst_n,
  // Level
  input  wire d,
  output reg  q
);
  reg meta_q;

  always @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      meta_q <= INIT;
      q      <= INIT;
    end else begin
      meta_q <= d;
      q      <= meta_q;
    end
  end
endmodule

// ==== src/scp_port.v ====
`timescale 1ns/1ps
`include "scp_regs.vh"
module scp_port #(
  parameter CHANNELS = 4
) (
  // Clock and reset
  input  wire       clk,
  input  wire       arst_n,
  // Host serial pins
  input  wire       sel_n,
  input  wire       host_shift_clock,
  input  wire       sdin,
  output reg        sdout_o,
  output reg        sdout_oe,
  // Channel for the coefficient class; per-channel class takes it from bits 6:5
  input  wire [1:0] chan_sel,
  // Write notification to the rest of the device
  output reg        wr_stb_q,
  output reg  [6:0] wr_addr_q,
  output reg  [7:0] wr_data_q
);
  localparam ST_IDLE = 2'd0;
  localparam ST_CMD  = 2'd1;
  localparam ST_WR   = 2'd2;
  localparam ST_RD   = 2'd3;

  wire       sel_n_s;
  wire       sck_s;
  wire       din_s;

  // Select and clock idle high; leaving reset low would fake an edge
  scp_sync #(
    .INIT (1'b1)
  ) u_sync_sel (
    .clk    (clk),
    .arst_n (arst_n),
    .d      (sel_n),
    .q      (sel_n_s)
  );
  scp_sync #(
    .INIT (1'b1)
  ) u_sync_sck (
    .clk    (clk),
    .arst_n (arst_n),
    .d      (host_shift_clock),
    .q      (sck_s)
  );
  scp_sync #(
    .INIT (1'b0)
  ) u_sync_din (
    .clk    (clk),
    .arst_n (arst_n),
    .d      (sdin),
    .q      (din_s)
  );

  reg  [7:0] mem [0:`SCP_MEM_DEPTH-1];
  reg  [1:0] st_q;
  reg        sck_prev_q;
  reg        sel_prev_q;
  reg  [2:0] bit_cnt_q;
  reg  [7:0] sh_q;
  reg  [7:0] tx_q;
  reg  [3:0] left_q;
  reg  [6:0] ptr_q;
  reg        tx_done_q;
  reg  [6:0] base;

  wire       rise;
  wire       fall;
  wire       start;
  wire [7:0] cmd;
  wire [1:0] cls;
  wire [3:0] cnt;
  wire [6:0] top_addr;
  wire       byte_end;
  wire       busy;
  wire       cmd_done;
  wire       wr_byte;
  wire       rd_fall;

  assign rise     = sck_s & ~sck_prev_q;
  assign fall     = ~sck_s & sck_prev_q;
  assign start    = ~sel_n_s & sel_prev_q;
  assign cmd      = {sh_q[6:0], din_s};
  assign cls      = cmd[`SCP_CMD_CLS_HI:`SCP_CMD_CLS_LO];
  assign cnt      = {1'b0, cmd[`SCP_CMD_CNT_HI:`SCP_CMD_CNT_LO]} + 4'd1;
  // Bytes go highest-numbered location first, down to offset zero
  assign top_addr = ptr_q + {3'b000, left_q} - `SCP_ADDR_ONE;
  assign byte_end = (bit_cnt_q == `SCP_BIT_CNT_LAST);
  assign busy     = ~sel_n_s & ~start;
  assign cmd_done = busy & (st_q == ST_CMD) & rise & byte_end;
  // Bytes beyond the commanded count are dropped
  assign wr_byte  = busy & (st_q == ST_WR) & rise & byte_end & (left_q != 4'h0);
  assign rd_fall  = busy & (st_q == ST_RD) & fall;

  // Class decode; bits 6:5 pick the channel bank, chan_sel the coefficient bank
  always @* begin
    case (cls)
      `SCP_CLS_CHAN: begin
        base = `SCP_BASE_CHAN + {2'b00, cmd[`SCP_CMD_ADR_HI:`SCP_CMD_ADR_LO], 3'b000};
      end
      `SCP_CLS_COMMON: begin
        base = `SCP_BASE_COMMON;
      end
      default: begin
        base = `SCP_BASE_COEF + {2'b00, chan_sel, 3'b000};
      end
    endcase
  end

  // Edge finders on the synchronised host lines
  always @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      sck_prev_q <= 1'b1;
      sel_prev_q <= 1'b1;
    end else begin
      sck_prev_q <= sck_s;
      sel_prev_q <= sel_n_s;
    end
  end

  // Register and coefficient storage
  integer i;
  always @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      for (i = 0; i < `SCP_MEM_DEPTH; i = i + 1) begin
        mem[i] <= `SCP_BYTE_ZERO;
      end
    end else if (wr_byte) begin
      mem[top_addr] <= cmd;
    end
  end

  // One pulse per stored byte for the rest of the device
  always @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      wr_stb_q  <= 1'b0;
      wr_addr_q <= `SCP_ADDR_ZERO;
      wr_data_q <= `SCP_BYTE_ZERO;
    end else begin
      wr_stb_q <= wr_byte;
      if (wr_byte) begin
        wr_addr_q <= top_addr;
        wr_data_q <= cmd;
      end
    end
  end

  // Receive side and sequencing
  always @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      st_q      <= ST_IDLE;
      bit_cnt_q <= 3'h0;
      sh_q      <= `SCP_BYTE_ZERO;
      left_q    <= 4'h0;
      ptr_q     <= `SCP_ADDR_ZERO;
    end else if (sel_n_s) begin
      // Abandon any partial byte
      st_q      <= ST_IDLE;
      bit_cnt_q <= 3'h0;
    end else if (start) begin
      st_q      <= ST_CMD;
      bit_cnt_q <= 3'h0;
    end else begin
      case (st_q)
        ST_CMD, ST_WR: begin
          // Sample on rising edge, MSB first
          if (rise) begin
            sh_q      <= cmd;
            // Pauses between bytes simply leave the counters alone
            bit_cnt_q <= bit_cnt_q + 3'h1;
            if (cmd_done) begin
              ptr_q  <= base;
              left_q <= cnt;
              if (cmd[`SCP_CMD_RW_BIT]) begin
                st_q <= ST_RD;
              end else begin
                st_q <= ST_WR;
              end
            end else if (wr_byte) begin
              left_q <= left_q - 4'h1;
            end
          end
        end
        ST_RD: begin
          // Input ignored and no new command while responding
          if (fall) begin
            bit_cnt_q <= bit_cnt_q + 3'h1;
            if (byte_end && left_q != 4'h0) begin
              left_q <= left_q - 4'h1;
            end
          end
        end
        default: begin
          st_q <= ST_IDLE;
        end
      endcase
    end
  end

  // Response side: identification byte, then the requested bytes
  always @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      tx_q      <= `SCP_BYTE_ZERO;
      tx_done_q <= 1'b0;
      sdout_o   <= 1'b0;
      sdout_oe  <= 1'b0;
    end else if (sel_n_s) begin
      sdout_oe  <= 1'b0;
      tx_done_q <= 1'b0;
    end else if (cmd_done) begin
      tx_q      <= `SCP_ID_BYTE;
      tx_done_q <= 1'b0;
    end else if (rd_fall) begin
      if (tx_done_q) begin
        // Last bit has been sampled; a strapped line is free again
        sdout_oe <= 1'b0;
      end else begin
        sdout_oe <= 1'b1;
        sdout_o  <= tx_q[7];
        if (byte_end) begin
          if (left_q != 4'h0) begin
            tx_q <= mem[top_addr];
          end else begin
            tx_q      <= `SCP_BYTE_ZERO;
            tx_done_q <= 1'b1;
          end
        end else begin
          tx_q <= {tx_q[6:0], 1'b0};
        end
      end
    end
  end
endmodule

// ==== bench/scp_port_properties.sv ====
`timescale 1ns/1ps
module scp_port_chk (
  // Watched ports
  input wire clk,
  input wire arst_n,
  input wire sel_n,
  input wire host_shift_clock,
  input wire sdout_o,
  input wire sdout_oe,
  input wire wr_stb_q
);
  default clocking @(posedge clk); endclocking
  default disable iff (!arst_n);
  // Six samples cover the select synchroniser and the output register
  sequence idle_s; sel_n [*6]; endsequence
  sequence pause_s; (host_shift_clock && !sel_n) [*8]; endsequence
  oe_idle_a: assert property (idle_s |-> !sdout_oe) else $error("oe idle");
  stb_pulse_a: assert property (wr_stb_q |=> !wr_stb_q) else $error("stb width");
  stb_edge_a: assert property (wr_stb_q |-> $past(host_shift_clock, 2)) else $error("stb");
  cmd_quiet_a: assert property ($fell(sel_n) |=> !sdout_oe [*8]) else $error("oe cmd");
  out_pause_a: assert property (pause_s |-> $stable(sdout_o)) else $error("out");
  oe_sel_a: assert property ($rose(sdout_oe) |-> !sel_n) else $error("oe sel");
  sel_end_a: assert property ($rose(sel_n) |-> ##[0:6] !sdout_oe) else $error("oe end");
  no_overlap_a: assert property (wr_stb_q |-> !sdout_oe) else $error("overlap");
endmodule
bind scp_port scp_port_chk i_scp_port_chk (.clk(clk), .arst_n(arst_n), .sel_n(sel_n),
  .host_shift_clock(host_shift_clock), .sdout_o(sdout_o), .sdout_oe(sdout_oe),
  .wr_stb_q(wr_stb_q));

// ==== bench/scp_host.sv ====
`timescale 1ns/1ps
module scp_host (
  // Host pins
  output reg  sel_n,
  output reg  host_shift_clock,
  output reg  sdin,
  input  wire sdout_o,
  input  wire sdout_oe
);
  // Strapped data line
  wire line = sdout_oe ? sdout_o : sdin;
  initial begin
    sel_n = 1'b1;
    host_shift_clock = 1'b1;
    sdin = 1'b1;
  end
  task start;
    begin
      #103 sel_n = 1'b0;
      #100;
    end
  endtask
  task stop;
    begin
      #40 sel_n = 1'b1;
      #200;
    end
  endtask
  task xfer(input [7:0] tx, input integer nb, input integer gap, output [7:0] rx);
    integer i;
    begin
      for (i = 7; i > 7 - nb; i = i - 1) begin
        #40 host_shift_clock = 1'b0;
        sdin = tx[i];
        #40 host_shift_clock = 1'b1;
        rx[i] = line;
      end
      // Clock held high between bytes
      #(gap);
    end
  endtask
endmodule

// ==== bench/test_scp_port.sv ====
`timescale 1ns/1ps
`include "scp_regs.vh"
module test_scp_port;
  reg         clk;
  reg         arst_n;
  reg  [1:0]  chan_sel;
  wire        sel_n, sck, sdin, sdout_o, sdout_oe, wr_stb_q;
  wire [6:0]  wr_addr_q;
  wire [7:0]  wr_data_q;
  integer     fail_count, checks, seed, i;
  integer     mem [0:127];
  reg  [14:0] got [$];
  reg  [14:0] exq [$];
  reg  [7:0]  rx;
  scp_port i_scp_port (.clk(clk), .arst_n(arst_n), .sel_n(sel_n), .host_shift_clock(sck),
    .sdin(sdin), .sdout_o(sdout_o), .sdout_oe(sdout_oe), .chan_sel(chan_sel),
    .wr_stb_q(wr_stb_q), .wr_addr_q(wr_addr_q), .wr_data_q(wr_data_q));
  scp_host i_scp_host (.sel_n(sel_n), .host_shift_clock(sck), .sdin(sdin),
    .sdout_o(sdout_o), .sdout_oe(sdout_oe));
  function integer rnd(input integer u);
    begin
      seed = seed ^ (seed << 13);
      seed = seed ^ (seed >> 17);
      seed = seed ^ (seed << 5);
      rnd = seed & 32'h7fffffff;
    end
  endfunction
  task chk(input [14:0] g, input [14:0] e);
    begin
      checks = checks + 1;
      if (g !== e) begin
        fail_count = fail_count + 1;
        $display("[ERR] %0t got %h exp %h", $time, g, e);
      end
    end
  endtask
  task acc(input [7:0] c);
    integer k, a;
    reg [7:0] d;
    begin
      @(negedge clk) chan_sel = 2'(rnd(0));
      i_scp_host.start;
      i_scp_host.xfer(c, 8, 40, rx);
      if (c[7]) i_scp_host.xfer(8'h00, 8, 40, rx);
      if (c[7]) chk({7'h00, rx}, {7'h00, `SCP_ID_BYTE});
      for (k = c[2:0]; k >= 0; k = k - 1) begin
        if (c[4:3] == 2'b11) a = 32'h20 + k;
        else if (c[4:3] == 2'b10) a = c[6:5] * 8 + k;
        else a = 32'h28 + chan_sel * 8 + k;
        d = rnd(0);
        // Junk on the input during a read must be ignored
        i_scp_host.xfer(d, 8, 40 + (d % 3) * 200, rx);
        if (c[7]) chk({7'h00, rx}, 15'(mem[a]));
        else begin
          mem[a] = d;
          exq.push_back({a[6:0], d});
        end
      end
      i_scp_host.stop;
      chk(15'(got.size()), 15'(exq.size()));
      while (got.size() > 0 && exq.size() > 0) chk(got.pop_front(), exq.pop_front());
      got.delete();
      exq.delete();
    end
  endtask
  task close_out;
    begin
      if (fail_count == 0 && checks > 0)
        $display("ALL CHECKS OK");
      else
        $display("CHECKS NOT OK");
      $finish;
    end
  endtask
  always @(negedge clk) if (wr_stb_q === 1'b1) got.push_back({wr_addr_q, wr_data_q});
  initial begin
    clk = 1'b0;
    forever #5 clk = ~clk;
  end
  initial begin
    #600000;
    fail_count = fail_count + 1;
    close_out;
  end
  initial begin
    arst_n = 1'b0;
    chan_sel = 2'h0;
    seed = 19;
    fail_count = 0;
    checks = 0;
    for (i = 0; i < 128; i = i + 1) mem[i] = 0;
    repeat (16) @(posedge clk);
    @(negedge clk) arst_n = 1'b1;
    for (i = 0; i < 4; i = i + 1) begin
      acc(8'(8'h17 | (i << 5)));
      acc(8'h07);
      acc(8'h87);
    end
    acc(8'h1f);
    // Select dropped inside a data byte: nothing stored
    i_scp_host.start;
    i_scp_host.xfer(8'h18, 8, 40, rx);
    i_scp_host.xfer(8'h77, 5, 40, rx);
    i_scp_host.stop;
    acc(8'h98);
    for (i = 0; i < 10; i = i + 1) acc(8'(rnd(0)));
    close_out;
  end
endmodule
